// ==== rtl/smcf_clkdiv.sv ====
`include "smcf_regs.svh"
module smcf_clkdiv
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Divider setup
	input wire smcf_pkg::smcf_base_frequency_select_t i_base_frequency_select,
	input wire logic i_third_divider_enable_en,
	input wire logic i_div_en,
	input wire smcf_pkg::smcf_period_t i_period,
	input wire smcf_pkg::smcf_period_t i_low,
	// Final interface clock as edge pulses and level
	output logic o_rise,
	output logic o_fall,
	output logic o_level
);
	import smcf_pkg::*;

	logic [6:0] pre_r;
	logic [1:0] d3_r;
	smcf_period_t per_r;

	// Base select picks a power-of-two share of the source clock
	wire [6:0] pre_last = 7'((`SMCF_PRE_UNIT << i_base_frequency_select) - `SMCF_PRE_UNIT);
	wire base_tick = (pre_r == pre_last);
	wire d3_tick = base_tick & (d3_r == `SMCF_THIRD_DIVIDER_ENABLE_LAST);
	wire stage_tick = i_third_divider_enable_en ? d3_tick : base_tick;
	wire per_wrap = (per_r == i_period);
	// Bypassed divider toggles on every stage tick, giving half the stage rate
	wire rise_nxt = stage_tick & (i_div_en ? (per_r == i_low) : ~o_level);
	wire fall_nxt = stage_tick & (i_div_en ? per_wrap : o_level);

	// Counters; enables only, since the design has a single clock
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pre_r <= 7'h00;
			d3_r <= 2'h0;
			per_r <= 8'h00;
		end
		else
		begin
			pre_r <= base_tick ? 7'h00 : pre_r + 7'h01;
			if (base_tick)
				d3_r <= (d3_r == `SMCF_THIRD_DIVIDER_ENABLE_LAST) ? 2'h0 : d3_r + 2'h1;
			if (stage_tick && i_div_en)
				per_r <= per_wrap ? 8'h00 : per_r + 8'h01;
		end
	end

	// Registered edge pulses and clock level
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			o_rise <= 1'b0;
			o_fall <= 1'b0;
			o_level <= 1'b0;
		end
		else
		begin
			o_rise <= rise_nxt;
			o_fall <= fall_nxt;
			o_level <= fall_nxt ? 1'b0 : (rise_nxt ? 1'b1 : o_level);
		end
	end
endmodule

// ==== rtl/smcf_pair_buf.sv ====
module smcf_pair_buf
#(
	parameter int W = 32,
	parameter int D = 2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Filling side
	input wire logic i_valid,
	input wire logic [W-1:0] i_data,
	output logic o_ready,
	// Draining side
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction

	wire push = i_valid & o_ready;
	wire pop = o_valid & i_ready;
	wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign o_data = mem[rp_r];

	// Storage written only on accepted words
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= i_data;
	end

	// Flags are registered from the next count, so full and empty are exact
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			o_ready <= 1'b1;
			o_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wp_r <= bump(wp_r);
			if (pop)
				rp_r <= bump(rp_r);
			cnt_r <= cnt_nxt;
			o_ready <= (cnt_nxt != (AW+1)'(D));
			o_valid <= (cnt_nxt != '0);
		end
	end
endmodule

// ==== rtl/smcf_pkg.sv ====
package smcf_pkg;
	typedef logic [31:0] smcf_word_t;
	typedef logic [7:0] smcf_byte_t;
	typedef logic [5:0] smcf_ptr_t;
	typedef logic [7:0] smcf_period_t;
	typedef logic [3:0] smcf_nib_t;
	typedef logic [2:0] smcf_base_frequency_select_t;
	typedef logic [15:0] smcf_span_t;
	typedef enum {SCL_IDLE, SCL_LOW, SCL_RISE, SCL_SYNC, SCL_HIGH} smcf_scl_t;
endpackage

// ==== rtl/smcf_regs.svh ====
`ifndef SMCF_REGS_SVH
`define SMCF_REGS_SVH

// Queue geometry, in bytes unless marked
`define SMCF_FIFO_BYTES 6'd32
`define SMCF_TX_SPACE_MAX 6'd28
`define SMCF_WORD_BYTES 6'd4
`define SMCF_WORD_INC 4'h1
`define SMCF_LANE_ZERO 2'h0
`define SMCF_BYTE_W 8
`define SMCF_PTR_RST 6'h00

// Bit counter within a serial byte
`define SMCF_BIT_FIRST 3'h0
`define SMCF_BIT_LAST 3'h7
`define SMCF_BIT_INC 3'h1

// Clock generation
`define SMCF_THIRD_DIVIDER_ENABLE_LAST 2'h2
`define SMCF_PRE_UNIT 8'h01
`define SMCF_CNT_ZERO 16'h0000

`endif

// ==== rtl/smcf_top.sv ====
`include "smcf_regs.svh"
// Notes on behaviour
// - In I2C mode SCL runs at half the final interface clock rate.
// - SCL duty is nominally even because the engine steps at twice bus rate.
// - Each SCL release waits a programmed number of source-clock cycles.
// - SCL high keeps its minimum span however late a slave lets go.
// - SCL is sampled every source cycle; a programmed run of highs confirms release.
// - In SPI mode the final interface clock drives the serial clock directly.
// - Two one-way 32-byte queues, transmit and receive, serve half and full duplex.
// - Word-only push and pop move pointers; unused bytes dropped or read as zero.
// - With DMA enabled the DMA ports fill and drain the queues instead.
// - Pointers and contents survive the end of a command.
// - A pointer-clear control zeroes both queue pointers.
// - Transfer pauses with the clock held while transmit empty or receive full.
// - A debug window reads queue words without moving any pointer.
// - The debug window writes the transmit queue only; receive is read-only.
// - Transmit write pointer and receive read pointer are visible.
// - Enabled divider spans period+1 input ticks, low for low+1 of them.
// - The divide-by-three stage is bypassed when its enable is zero.
module smcf_top
(
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	// Clock setup
	input wire logic I_MODE_SPI,
	input wire smcf_pkg::smcf_base_frequency_select_t I_BASE_FREQUENCY_SELECT,
	input wire logic I_THIRD_DIVIDER_ENABLE,
	input wire logic I_PROGRAMMABLE_DIVIDER_ENABLE,
	input wire smcf_pkg::smcf_period_t I_DIVIDER_PERIOD,
	input wire smcf_pkg::smcf_period_t I_DIVIDER_LOW_COUNT,
	input wire smcf_pkg::smcf_nib_t I_SCL_RISE_DELAY,
	input wire smcf_pkg::smcf_nib_t I_SDA_OUTPUT_DELAY,
	input wire smcf_pkg::smcf_nib_t I_STRETCH_SAMPLE_COUNT,
	// Transfer control and status
	input wire logic I_XFER_ACTIVE,
	input wire logic I_XFER_WRITE,
	input wire logic I_XFER_READ,
	input wire logic I_DMA_EN,
	output logic O_XFER_STALLED,
	// Transmit word push, software and DMA
	input wire logic I_TX_WORD_PUSH,
	input wire smcf_pkg::smcf_word_t I_TX_WORD_PUSH_DATA,
	input wire logic I_DMA_TX_VALID,
	input wire smcf_pkg::smcf_word_t I_DMA_TX_DATA,
	output logic O_TX_READY,
	// Receive word pop, software and DMA
	output logic O_RX_WORD_POP_VALID,
	output smcf_pkg::smcf_word_t O_RX_WORD_POP_DATA,
	input wire logic I_RX_WORD_POP_READY,
	input wire logic I_DMA_RX_READY,
	// Pointer clear and view
	input wire logic I_QUEUE_POINTER_CLEAR,
	output smcf_pkg::smcf_ptr_t O_QUEUE_POINTER_VIEW_TX,
	output smcf_pkg::smcf_ptr_t O_QUEUE_POINTER_VIEW_RX,
	// Debug queue window
	input wire logic I_DBG_RD,
	input wire logic I_DBG_WR,
	input wire logic I_DBG_RX_SEL,
	input wire logic [2:0] I_DBG_ADDR,
	input wire smcf_pkg::smcf_word_t I_DBG_WDATA,
	output smcf_pkg::smcf_word_t O_DEBUG_QUEUE_WINDOW_DATA,
	// Serial pins
	output logic O_SCL_OE,
	input wire logic I_SCL_IN,
	output logic O_SDA_OE,
	input wire logic I_SDA_IN,
	output logic O_SCK,
	output logic O_MOSI,
	input wire logic I_MISO
);
	import smcf_pkg::*;

	// Queue storage, one word per entry
	smcf_word_t tx_mem [8];
	smcf_word_t rx_mem [8];
	smcf_ptr_t tx_wptr_r, tx_rptr_r, rx_wptr_r, rx_rptr_r;
	smcf_ptr_t tx_wptr_nxt, tx_rptr_nxt, rx_wptr_nxt, rx_rptr_nxt;

	// Pin synchronisers
	logic [1:0] scl_sync_r, sda_sync_r, miso_sync_r;

	// Clock engine state
	smcf_scl_t scl_st_r, scl_st_nxt;
	smcf_nib_t rise_cnt_r, smp_cnt_r, sdo_dly_r;
	smcf_span_t ph_cnt_r, ph_len_r, hi_cnt_r;
	logic sck_r, sdo_r;
	logic [2:0] bit_cnt_r;
	smcf_byte_t tx_sh_r, rx_sh_r;
	logic div_rise, div_fall, div_level;

	// Keeps the valid lanes of a partly filled receive word
	function automatic smcf_word_t lane_keep(input smcf_ptr_t cnt);
		unique case (cnt[1:0])
			2'h1: lane_keep = 32'h0000_00ff;
			2'h2: lane_keep = 32'h0000_ffff;
			2'h3: lane_keep = 32'h00ff_ffff;
			default: lane_keep = 32'hffff_ffff;
		endcase
	endfunction

	// Picks one byte lane from a queue word
	function automatic smcf_byte_t lane_of(input smcf_word_t w, input logic [1:0] lane);
		lane_of = w[lane * `SMCF_BYTE_W +: `SMCF_BYTE_W];
	endfunction

	smcf_clkdiv u_div
	(
		.clk(I_SYS_CLK),
		.nrst(I_NRST),
		.i_base_frequency_select(I_BASE_FREQUENCY_SELECT),
		.i_third_divider_enable_en(I_THIRD_DIVIDER_ENABLE),
		.i_div_en(I_PROGRAMMABLE_DIVIDER_ENABLE),
		.i_period(I_DIVIDER_PERIOD),
		.i_low(I_DIVIDER_LOW_COUNT),
		.o_rise(div_rise),
		.o_fall(div_fall),
		.o_level(div_level)
	);

	// Queue fill levels and flags
	wire [5:0] tx_cnt = tx_wptr_r - tx_rptr_r;
	wire [5:0] rx_cnt = rx_wptr_r - rx_rptr_r;
	wire tx_empty = (tx_cnt == `SMCF_PTR_RST);
	wire rx_full = (rx_cnt == `SMCF_FIFO_BYTES);
	wire first_bit = (bit_cnt_r == `SMCF_BIT_FIRST);
	wire last_bit = (bit_cnt_r == `SMCF_BIT_LAST);
	// Pausing only at a byte boundary keeps a byte whole on the wire
	wire stall = I_XFER_ACTIVE & first_bit & ((I_XFER_WRITE & tx_empty) | (I_XFER_READ & rx_full));

	// Word push: DMA port replaces software port while DMA is enabled
	wire push_req = I_DMA_EN ? I_DMA_TX_VALID : I_TX_WORD_PUSH;
	wire smcf_word_t push_data = I_DMA_EN ? I_DMA_TX_DATA : I_TX_WORD_PUSH_DATA;
	wire push_ev = push_req & O_TX_READY & ~I_QUEUE_POINTER_CLEAR;

	// Word pop into the two-entry buffer; a partial word only once idle
	wire rx_whole = (rx_cnt >= `SMCF_WORD_BYTES);
	// Tail pop waits for idle so a running byte stream is never cut mid-word
	wire rx_tail = ~I_XFER_ACTIVE & (rx_cnt != `SMCF_PTR_RST);
	wire buf_ready;
	wire pop_ev = (rx_whole | rx_tail) & buf_ready & ~I_QUEUE_POINTER_CLEAR;
	wire smcf_word_t pop_word = rx_mem[rx_rptr_r[4:2]] & lane_keep(rx_whole ? `SMCF_WORD_BYTES : rx_cnt);
	wire drain_ready = I_DMA_EN ? I_DMA_RX_READY : I_RX_WORD_POP_READY;

	smcf_pair_buf #(.W(32), .D(2)) u_rx_buf
	(
		.clk(I_SYS_CLK),
		.nrst(I_NRST),
		.i_valid(pop_ev),
		.i_data(pop_word),
		.o_ready(buf_ready),
		.o_valid(O_RX_WORD_POP_VALID),
		.o_data(O_RX_WORD_POP_DATA),
		.i_ready(drain_ready)
	);

	// Serial events: sample on the rising clock, launch while the clock is low
	wire din = I_MODE_SPI ? miso_sync_r[1] : sda_sync_r[1];
	wire spi_samp = I_MODE_SPI & I_XFER_ACTIVE & div_rise & ~stall;
	wire i2c_samp = ~I_MODE_SPI & (scl_st_r == SCL_SYNC) & (scl_st_nxt == SCL_HIGH);
	wire samp_ev = spi_samp | i2c_samp;
	wire spi_fall = I_MODE_SPI & div_fall & sck_r;
	wire i2c_fall = ~I_MODE_SPI & (scl_st_r == SCL_HIGH) & (scl_st_nxt != SCL_HIGH);
	wire fall_ev = spi_fall | i2c_fall;
	wire clk_low = I_MODE_SPI ? ~sck_r : (scl_st_r == SCL_LOW);
	wire smcf_byte_t tx_head = lane_of(tx_mem[tx_rptr_r[4:2]], tx_rptr_r[1:0]);
	wire cur_bit = ~I_XFER_WRITE | (first_bit ? tx_head[7] : tx_sh_r[7]);
	wire tx_take = samp_ev & first_bit & I_XFER_WRITE;
	wire rx_put = samp_ev & last_bit & I_XFER_READ;
	wire smcf_byte_t rx_byte = {rx_sh_r[6:0], din};

	// Pointer next values; clear wins over every move
	always_comb
	begin
		tx_wptr_nxt = tx_wptr_r;
		tx_rptr_nxt = tx_rptr_r;
		rx_wptr_nxt = rx_wptr_r;
		rx_rptr_nxt = rx_rptr_r;
		if (I_QUEUE_POINTER_CLEAR)
		begin
			tx_wptr_nxt = `SMCF_PTR_RST;
			tx_rptr_nxt = `SMCF_PTR_RST;
			rx_wptr_nxt = `SMCF_PTR_RST;
			rx_rptr_nxt = `SMCF_PTR_RST;
		end
		else
		begin
			if (push_ev)
				tx_wptr_nxt = {tx_wptr_r[5:2] + `SMCF_WORD_INC, `SMCF_LANE_ZERO};
			if (tx_take)
				tx_rptr_nxt = tx_rptr_r + 6'h01;
			if (rx_put)
				rx_wptr_nxt = rx_wptr_r + 6'h01;
			if (pop_ev)
				rx_rptr_nxt = {rx_rptr_r[5:2] + `SMCF_WORD_INC, `SMCF_LANE_ZERO};
			// A tail pop also aligns the writer to the next word
			if (pop_ev && !rx_whole)
				rx_wptr_nxt = rx_rptr_nxt;
		end
	end

	// Pointers are not touched at command end, only by moves or clear
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
		begin
			tx_wptr_r <= `SMCF_PTR_RST;
			tx_rptr_r <= `SMCF_PTR_RST;
			rx_wptr_r <= `SMCF_PTR_RST;
			rx_rptr_r <= `SMCF_PTR_RST;
			O_TX_READY <= 1'b1;
		end
		else
		begin
			tx_wptr_r <= tx_wptr_nxt;
			tx_rptr_r <= tx_rptr_nxt;
			rx_wptr_r <= rx_wptr_nxt;
			rx_rptr_r <= rx_rptr_nxt;
			O_TX_READY <= ((tx_wptr_nxt - tx_rptr_nxt) <= `SMCF_TX_SPACE_MAX);
		end
	end

	// Transmit storage: pushes, and debug writes which move no pointer
	always_ff @(posedge I_SYS_CLK)
	begin
		if (push_ev)
			tx_mem[tx_wptr_r[4:2]] <= push_data;
		else if (I_DBG_WR && !I_DBG_RX_SEL)
			tx_mem[I_DBG_ADDR] <= I_DBG_WDATA;
	end

	// Receive storage: only the serial engine writes it
	always_ff @(posedge I_SYS_CLK)
	begin
		if (rx_put)
			rx_mem[rx_wptr_r[4:2]][rx_wptr_r[1:0] * `SMCF_BYTE_W +: `SMCF_BYTE_W] <= rx_byte;
	end

	// Debug window read and pointer view
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
			O_DEBUG_QUEUE_WINDOW_DATA <= 32'h0000_0000;
		else if (I_DBG_RD)
			O_DEBUG_QUEUE_WINDOW_DATA <= I_DBG_RX_SEL ? rx_mem[I_DBG_ADDR] : tx_mem[I_DBG_ADDR];
	end
	assign O_QUEUE_POINTER_VIEW_TX = tx_wptr_r;
	assign O_QUEUE_POINTER_VIEW_RX = rx_rptr_r;

	// Two-flop synchronisers for the pins
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			miso_sync_r <= 2'h0;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], I_SCL_IN};
			sda_sync_r <= {sda_sync_r[0], I_SDA_IN};
			miso_sync_r <= {miso_sync_r[0], I_MISO};
		end
	end

	// Phase length between interface-clock rises, in source cycles
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
		begin
			ph_cnt_r <= `SMCF_CNT_ZERO;
			ph_len_r <= `SMCF_CNT_ZERO;
		end
		else if (div_rise)
		begin
			ph_cnt_r <= 16'h0001;
			ph_len_r <= ph_cnt_r;
		end
		else
			ph_cnt_r <= ph_cnt_r + 16'h0001;
	end

	// SCL sequencing; one state step per interface-clock rise gives SCL at half rate
	wire smp_done = ({1'b0, smp_cnt_r} + 5'h01) >= {1'b0, I_STRETCH_SAMPLE_COUNT};
	wire [15:0] hi_load = (ph_len_r > {12'h000, I_SCL_RISE_DELAY}) ? ph_len_r - {12'h000, I_SCL_RISE_DELAY} : 16'h0001;
	always_comb
	begin
		scl_st_nxt = scl_st_r;
		unique case (scl_st_r)
			SCL_IDLE:
				if (I_XFER_ACTIVE && !I_MODE_SPI)
					scl_st_nxt = SCL_LOW;
			SCL_LOW:
				if (!I_XFER_ACTIVE)
					scl_st_nxt = SCL_IDLE;
				else if (div_rise && !stall)
					scl_st_nxt = SCL_RISE;
			SCL_RISE:
				if (rise_cnt_r == 4'h0)
					scl_st_nxt = SCL_SYNC;
			SCL_SYNC:
				if (scl_sync_r[1] && smp_done)
					scl_st_nxt = SCL_HIGH;
			SCL_HIGH:
				if (hi_cnt_r <= 16'h0001)
					scl_st_nxt = I_XFER_ACTIVE ? SCL_LOW : SCL_IDLE;
		endcase
	end

	// SCL counters and state register
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
		begin
			scl_st_r <= SCL_IDLE;
			rise_cnt_r <= 4'h0;
			smp_cnt_r <= 4'h0;
			hi_cnt_r <= `SMCF_CNT_ZERO;
		end
		else
		begin
			scl_st_r <= scl_st_nxt;
			rise_cnt_r <= (scl_st_r == SCL_LOW) ? I_SCL_RISE_DELAY : rise_cnt_r - {3'h0, (rise_cnt_r != 4'h0)};
			// A low sample restarts the run, so a stretch is seen within one bus cycle
			smp_cnt_r <= (scl_st_r == SCL_SYNC && scl_sync_r[1]) ? smp_cnt_r + 4'h1 : 4'h0;
			hi_cnt_r <= (scl_st_nxt == SCL_HIGH && scl_st_r != SCL_HIGH) ? hi_load : hi_cnt_r - {15'h0000, (hi_cnt_r != `SMCF_CNT_ZERO)};
		end
	end

	// Byte shifter; an inactive transfer restarts at the first bit
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST || !I_XFER_ACTIVE)
		begin
			bit_cnt_r <= `SMCF_BIT_FIRST;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
		end
		else if (samp_ev)
		begin
			bit_cnt_r <= bit_cnt_r + `SMCF_BIT_INC;
			tx_sh_r <= first_bit ? {tx_head[6:0], 1'b0} : {tx_sh_r[6:0], 1'b0};
			rx_sh_r <= rx_byte;
		end
	end

	// Pin drivers and status, all registered except O_SDA_OE, which I_MODE_SPI gates directly
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_NRST)
		begin
			sck_r <= 1'b0;
			sdo_r <= 1'b1;
			sdo_dly_r <= 4'h0;
			O_SCL_OE <= 1'b0;
			O_XFER_STALLED <= 1'b0;
		end
		else
		begin
			if (!I_MODE_SPI || !I_XFER_ACTIVE)
				sck_r <= 1'b0;
			else if (div_rise && !stall)
				sck_r <= 1'b1;
			else if (div_fall)
				sck_r <= 1'b0;
			// Data launches a set delay after the clock falls
			if (fall_ev)
				sdo_dly_r <= I_SDA_OUTPUT_DELAY;
			else if (sdo_dly_r != 4'h0)
				sdo_dly_r <= sdo_dly_r - 4'h1;
			else if (clk_low)
				sdo_r <= cur_bit;
			O_SCL_OE <= (scl_st_nxt == SCL_LOW) || (scl_st_nxt == SCL_RISE);
			O_XFER_STALLED <= stall;
		end
	end
	assign O_SCK = sck_r;
	assign O_MOSI = sdo_r;
	assign O_SDA_OE = ~I_MODE_SPI & ~sdo_r;
	// Note: partial-word tail pops are never taken during a transfer
endmodule

// ==== sim/smcf_slave_model.sv ====
module smcf_slave_model
#(
	parameter logic [7:0] RX_PAT = 8'ha5
)
(
	// Lines from the master
	input wire logic i_spi,
	input wire logic i_scl_oe,
	input wire logic i_sda_oe,
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_stretch,
	// Lines back to the master
	output logic o_scl,
	output logic o_sda,
	output logic o_miso,
	// Each byte seen on the data-out line
	output logic [7:0] o_byte,
	output logic o_byte_tgl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] bit_r;
	// Pulled-up open-drain lines; the slave may hold the clock low to stretch it
	assign o_scl = !(i_scl_oe || i_stretch);
	assign o_sda = !i_sda_oe;
	initial
	begin
		bit_r = 3'h0;
		o_miso = RX_PAT[7];
		o_byte = 8'h00;
		o_byte_tgl = 1'b0;
	end
	// Sample on the rising clock edge, most significant bit first
	always @(posedge i_sck)
	begin
		if (i_spi)
		begin
			o_byte = {o_byte[6:0], i_mosi};
			if (bit_r == 3'h7)
				o_byte_tgl = !o_byte_tgl;
			bit_r = bit_r + 3'h1;
		end
	end
	// Change returned data after the falling edge, clear of the master's synchroniser
	always @(negedge i_sck)
		o_miso = RX_PAT[3'h7 - bit_r];
endmodule

// ==== sim/smcf_top_properties.sv ====
module smcf_chk
(
	// Clock, reset and controls
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic I_MODE_SPI,
	input wire logic I_XFER_ACTIVE,
	input wire logic I_DMA_EN,
	input wire logic I_TX_WORD_PUSH,
	input wire logic I_DMA_TX_VALID,
	input wire logic I_RX_WORD_POP_READY,
	input wire logic I_DMA_RX_READY,
	input wire logic I_QUEUE_POINTER_CLEAR,
	input wire logic I_SCL_IN,
	// Outputs under watch
	input wire logic O_XFER_STALLED,
	input wire logic O_TX_READY,
	input wire logic O_RX_WORD_POP_VALID,
	input wire smcf_pkg::smcf_word_t O_RX_WORD_POP_DATA,
	input wire smcf_pkg::smcf_ptr_t O_QUEUE_POINTER_VIEW_TX,
	input wire smcf_pkg::smcf_ptr_t O_QUEUE_POINTER_VIEW_RX,
	input wire logic O_SCL_OE,
	input wire logic O_SDA_OE,
	input wire logic O_SCK
);
	import smcf_pkg::*;
	default clocking dc @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_NRST);
	// Accepted push and drain readiness, whichever source is selected
	wire logic push_go = (I_DMA_EN ? I_DMA_TX_VALID : I_TX_WORD_PUSH) && O_TX_READY && !I_QUEUE_POINTER_CLEAR;
	wire logic pop_rdy = I_DMA_EN ? I_DMA_RX_READY : I_RX_WORD_POP_READY;
	chk_reset_values: assert property ($rose(I_NRST) |-> O_TX_READY && !O_RX_WORD_POP_VALID && !O_SCL_OE &&
		!O_SDA_OE && !O_XFER_STALLED && O_QUEUE_POINTER_VIEW_TX == 6'h00 && O_QUEUE_POINTER_VIEW_RX == 6'h00)
		else $error("outputs wrong after reset");
	chk_clear_zero: assert property (I_QUEUE_POINTER_CLEAR |=>
		O_QUEUE_POINTER_VIEW_TX == 6'h00 && O_QUEUE_POINTER_VIEW_RX == 6'h00)
		else $error("pointer clear did not zero views");
	chk_push_step: assert property (push_go |=>
		O_QUEUE_POINTER_VIEW_TX == $past(O_QUEUE_POINTER_VIEW_TX) + 6'h04)
		else $error("push did not advance one word");
	chk_tx_ptr_hold: assert property (!push_go && !I_QUEUE_POINTER_CLEAR |=> $stable(O_QUEUE_POINTER_VIEW_TX))
		else $error("write pointer moved without push");
	chk_pop_hold: assert property (O_RX_WORD_POP_VALID && !pop_rdy && !I_QUEUE_POINTER_CLEAR |=>
		O_RX_WORD_POP_VALID && $stable(O_RX_WORD_POP_DATA))
		else $error("pop word lost while stalled");
	chk_spi_no_scl: assert property (I_MODE_SPI [*3] |-> !O_SCL_OE && !O_SDA_OE)
		else $error("open-drain lines driven in spi mode");
	chk_stall_hold: assert property (O_XFER_STALLED [*2] |-> !$rose(O_SCK) && !$fell(O_SCL_OE))
		else $error("clock moved while stalled");
	chk_stall_idle: assert property (!I_XFER_ACTIVE [*2] |-> !O_XFER_STALLED)
		else $error("stall flagged with no transfer");
	chk_scl_min_high: assert property (!I_MODE_SPI && $rose(I_SCL_IN) |-> !O_SCL_OE [*4])
		else $error("scl high time cut short");
endmodule

bind smcf_top smcf_chk i_chk (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_MODE_SPI(I_MODE_SPI),
	.I_XFER_ACTIVE(I_XFER_ACTIVE), .I_DMA_EN(I_DMA_EN), .I_TX_WORD_PUSH(I_TX_WORD_PUSH),
	.I_DMA_TX_VALID(I_DMA_TX_VALID), .I_RX_WORD_POP_READY(I_RX_WORD_POP_READY), .I_DMA_RX_READY(I_DMA_RX_READY),
	.I_QUEUE_POINTER_CLEAR(I_QUEUE_POINTER_CLEAR), .I_SCL_IN(I_SCL_IN), .O_XFER_STALLED(O_XFER_STALLED),
	.O_TX_READY(O_TX_READY), .O_RX_WORD_POP_VALID(O_RX_WORD_POP_VALID), .O_RX_WORD_POP_DATA(O_RX_WORD_POP_DATA),
	.O_QUEUE_POINTER_VIEW_TX(O_QUEUE_POINTER_VIEW_TX), .O_QUEUE_POINTER_VIEW_RX(O_QUEUE_POINTER_VIEW_RX),
	.O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_SCK(O_SCK));

// ==== sim/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import smcf_pkg::*;
	localparam int LIMIT = 3000;
	logic clk, nrst, spi, third_divider_enable, div_en, act, wr, rd, dma, push, dma_v, pop_rdy, dma_rdy, clr;
	logic dbg_rd, dbg_wr, dbg_rx, stretch, btgl_d, dbg_pend;
	smcf_base_frequency_select_t base_frequency_select;
	smcf_period_t per, low;
	smcf_nib_t rdly, sdly, scnt;
	smcf_word_t push_d, dma_d, dbg_wd, w;
	logic [2:0] dbg_a;
	wire logic stalled, tx_rdy, pop_v, scl_oe, sda_oe, scl, sda, sck, mosi, miso, btgl;
	wire smcf_word_t pop_d, dbg_q;
	wire smcf_ptr_t v_tx, v_rx;
	wire logic [7:0] sbyte;
	int err_total, n_compared, i;
	smcf_word_t q_word[$], q_dbg[$], sent[$];
	logic [7:0] q_byte[$];

	smcf_top i_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_MODE_SPI(spi), .I_BASE_FREQUENCY_SELECT(base_frequency_select),
		.I_THIRD_DIVIDER_ENABLE(third_divider_enable), .I_PROGRAMMABLE_DIVIDER_ENABLE(div_en), .I_DIVIDER_PERIOD(per),
		.I_DIVIDER_LOW_COUNT(low), .I_SCL_RISE_DELAY(rdly), .I_SDA_OUTPUT_DELAY(sdly), .I_STRETCH_SAMPLE_COUNT(scnt),
		.I_XFER_ACTIVE(act), .I_XFER_WRITE(wr), .I_XFER_READ(rd), .I_DMA_EN(dma), .O_XFER_STALLED(stalled),
		.I_TX_WORD_PUSH(push), .I_TX_WORD_PUSH_DATA(push_d), .I_DMA_TX_VALID(dma_v), .I_DMA_TX_DATA(dma_d),
		.O_TX_READY(tx_rdy), .O_RX_WORD_POP_VALID(pop_v), .O_RX_WORD_POP_DATA(pop_d), .I_RX_WORD_POP_READY(pop_rdy),
		.I_DMA_RX_READY(dma_rdy), .I_QUEUE_POINTER_CLEAR(clr), .O_QUEUE_POINTER_VIEW_TX(v_tx),
		.O_QUEUE_POINTER_VIEW_RX(v_rx), .I_DBG_RD(dbg_rd), .I_DBG_WR(dbg_wr), .I_DBG_RX_SEL(dbg_rx),
		.I_DBG_ADDR(dbg_a), .I_DBG_WDATA(dbg_wd), .O_DEBUG_QUEUE_WINDOW_DATA(dbg_q), .O_SCL_OE(scl_oe),
		.I_SCL_IN(scl), .O_SDA_OE(sda_oe), .I_SDA_IN(sda), .O_SCK(sck), .O_MOSI(mosi), .I_MISO(miso));
	smcf_slave_model i_slave (.i_spi(spi), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_sck(sck), .i_mosi(mosi),
		.i_stretch(stretch), .o_scl(scl), .o_sda(sda), .o_miso(miso), .o_byte(sbyte), .o_byte_tgl(btgl));

	// 10 MHz source clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic tally(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_word(input smcf_word_t g, input smcf_word_t e);
		tally(g, e);
	endtask
	task automatic cmp_ptr(input smcf_ptr_t g, input smcf_ptr_t e);
		tally({26'h0, g}, {26'h0, e});
	endtask
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		tally({24'h0, g}, {24'h0, e});
	endtask
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic give_up();
		err_total++;
		end_of_test();
	endtask
	// Bounded wait on the stall flag (0) or the clock drive (1)
	task automatic wait_lvl(input int s, input logic lvl);
		int n;
		for (n = 0; n < LIMIT && (s == 0 ? stalled : scl_oe) !== lvl; n++)
			@(posedge clk);
		if ((s == 0 ? stalled : scl_oe) !== lvl)
			give_up();
	endtask
	// Push random words back to back, holding the strobe between them
	task automatic push_n(input int n);
		push <= 1'b1;
		repeat (n)
		begin
			w = $urandom;
			push_d <= w;
			sent.push_back(w);
			@(posedge clk);
		end
		push <= 1'b0;
	endtask
	// Words leave low byte first
	task automatic note_bytes();
		while (sent.size() > 0)
		begin
			w = sent.pop_front();
			for (int k = 0; k < 4; k++)
				q_byte.push_back(w[8*k +: 8]);
		end
	endtask
	// One debug access; spaced two edges so strobes never collide
	task automatic dbg(input logic wr_en, input logic rx, input logic [2:0] a, input smcf_word_t d);
		dbg_rd <= !wr_en;
		dbg_wr <= wr_en;
		dbg_rx <= rx;
		dbg_a <= a;
		dbg_wd <= d;
		if (!wr_en)
			q_dbg.push_back(d);
		@(posedge clk);
		dbg_rd <= 1'b0;
		dbg_wr <= 1'b0;
		@(posedge clk);
	endtask
	// Drain with a randomly stalling reader
	task automatic drain();
		int n;
		for (n = 0; n < LIMIT && q_word.size() > 0; n++)
		begin
			pop_rdy <= 1'($urandom);
			@(posedge clk);
		end
		pop_rdy <= 1'b0;
		if (q_word.size() > 0)
			give_up();
	endtask

	// Match each result at the outputs against the oldest note
	always @(posedge clk)
	begin
		if (dbg_pend)
			cmp_word(dbg_q, q_dbg.pop_front());
		dbg_pend <= dbg_rd;
		if (nrst && pop_v && pop_rdy)
			cmp_word(pop_d, q_word.pop_front());
		if (btgl !== btgl_d)
			cmp_byte(sbyte, q_byte.pop_front());
		btgl_d <= btgl;
	end

	initial
	begin
		{nrst, third_divider_enable, act, wr, rd, dma, push, dma_v, pop_rdy, dma_rdy, clr, dbg_rd, dbg_wr, dbg_rx, stretch} = '0;
		{btgl_d, dbg_pend, push_d, dma_d, dbg_wd, dbg_a} = '0;
		{spi, div_en} = 2'h3;
		base_frequency_select = 3'h0;
		per = 8'h07;
		low = 8'h03; // Short divider set keeps the run brief
		{rdly, sdly, scnt} = {4'h2, 4'h1, 4'h2}; // Sample count well under the eight-cycle phase
		err_total = 0;
		n_compared = 0;
		void'($urandom(32'h5275));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		cmp_ptr(v_tx, 6'h00);
		$display("Reset test done");
		// Fill the transmit queue, then try one push too many
		push_n(8);
		@(posedge clk);
		cmp_ptr({5'h0, tx_rdy}, 6'h00);
		push <= 1'b1;
		@(posedge clk);
		push <= 1'b0;
		@(posedge clk);
		cmp_ptr(v_tx, 6'h20);
		for (i = 0; i < 8; i++)
			dbg(1'b0, 1'b0, 3'(i), sent[i]);
		w = $urandom;
		sent[0] = w;
		dbg(1'b1, 1'b0, 3'h0, w);
		dbg(1'b0, 1'b0, 3'h0, w);
		cmp_ptr(v_tx, 6'h20);
		cmp_ptr(v_rx, 6'h00);
		$display("Push and window test done");
		// Full-duplex serial transfer until the transmit queue runs dry
		note_bytes();
		repeat (8) q_word.push_back(32'ha5a5a5a5);
		{act, wr, rd} <= 3'h7;
		wait_lvl(0, 1'b1);
		cmp_word(32'(q_byte.size()), 32'h0);
		repeat (20) @(posedge clk);
		push_n(1);
		note_bytes();
		q_word.push_back(32'ha5a5a5a5);
		wait_lvl(0, 1'b0);
		wait_lvl(0, 1'b1);
		cmp_word(32'(q_byte.size()), 32'h0);
		{act, wr, rd} <= 3'h0;
		drain();
		cmp_ptr(v_tx, 6'h24);
		cmp_ptr(v_rx, 6'h24);
		dbg(1'b0, 1'b1, 3'h0, 32'ha5a5a5a5);
		dbg(1'b1, 1'b1, 3'h0, 32'h00000000);
		dbg(1'b0, 1'b1, 3'h0, 32'ha5a5a5a5);
		$display("Serial transfer test done");
		// Two-wire mode with a slave stretching the clock
		spi <= 1'b0;
		{act, wr} <= 2'h3;
		push_n(1);
		sent.delete();
		wait_lvl(1, 1'b1);
		wait_lvl(1, 1'b0);
		stretch <= 1'b1;
		repeat (30) @(posedge clk);
		stretch <= 1'b0;
		wait_lvl(1, 1'b1);
		repeat (200) @(posedge clk);
		{act, wr} <= 2'h0;
		repeat (4) @(posedge clk);
		cmp_ptr(v_tx, 6'h28);
		$display("Clock stretch test done");
		// Pointer clear
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		@(posedge clk);
		cmp_ptr(v_tx, 6'h00);
		cmp_ptr(v_rx, 6'h00);
		$display("Pointer clear test done");
		// DMA source fills the queue; software stays off the push port meanwhile
		w = $urandom;
		{dma, dma_v} <= 2'h3;
		dma_d <= w;
		@(posedge clk);
		dma_v <= 1'b0;
		@(posedge clk);
		cmp_ptr(v_tx, 6'h04);
		dbg(1'b0, 1'b0, 3'h0, w);
		$display("DMA test done");
		end_of_test();
	end
endmodule
